// *** rtl/ldef_apb_if.sv ***
// Purpose: apb slave front end, decodes word index and strobes
// Assumes: zero wait state, pready always high in access phase
// Notes:   unmapped index gives pslverr, reads as zero
`timescale 1ns/10ps
module ldef_apb_if
    import ldef_pkg::*;
(
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    output logic                   wr_en,
    output logic                   rd_en,
    output logic      [IDX_W-1:0]  idx
);

    logic                          in_range;

    // access phase strobes, index from word address; upper address bits must be zero
    assign in_range = ~|paddr[ADDR_W-1:IDX_W+2];
    assign idx      = paddr[IDX_W+1:2];
    assign wr_en    = psel & penable & pwrite & in_range;
    assign rd_en    = psel & penable & ~pwrite & in_range;

endmodule // ldef_apb_if

// *** rtl/ldef_flag_bank.sv ***
// Purpose: sticky per-channel fault flags with a bulk clear
// Assumes: detect inputs are synchronous to mclk
// Notes:   a detect in the clear cycle wins over the clear
`timescale 1ns/10ps
module ldef_flag_bank
    import ldef_pkg::*;
#(
    parameter int unsigned N = NUM_CHANNELS
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic [N-1:0] detect,
    input  wire logic         clear,
    output logic      [N-1:0] flags_r,
    output logic              any_r
);

    // -----------------------------------------------------------------
    // per channel sticky flag
    // -----------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                flags_r[i] <= 1'b0;
            end else if (detect[i]) begin
                flags_r[i] <= 1'b1;
            end else if (clear) begin
                flags_r[i] <= 1'b0;
            end
        end
    end

    // summary follows the per channel flags
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            any_r <= 1'b0;
        end else begin
            any_r <= (|detect) | ((|flags_r) & ~clear);
        end
    end

endmodule // ldef_flag_bank

// *** rtl/ldef_pkg.sv ***
// Purpose: constants of the led channel enable and fault register bank
// Assumes: apb register window, one byte-wide register per aligned word
// Notes:   printed offsets are not all multiples of four, so they are indices
package ldef_pkg;

    // -----------------------------------------------------------------
    // widths
    // -----------------------------------------------------------------
    localparam int unsigned NUM_CHANNELS = 18;
    localparam int unsigned REG_W        = 8;
    localparam int unsigned IDX_W        = 8;
    localparam int unsigned ADDR_W       = 12;

    // -----------------------------------------------------------------
    // register indices, byte address is four times the index
    // -----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_CHANNEL_ENABLE_MID   = 8'h44;
    localparam logic [IDX_W-1:0] IDX_CHANNEL_ENABLE_TOP   = 8'h45;
    localparam logic [IDX_W-1:0] IDX_GLOBAL_FAULT_SUMMARY = 8'h64;
    localparam logic [IDX_W-1:0] IDX_OPEN_STATUS_LOW      = 8'h65;
    localparam logic [IDX_W-1:0] IDX_OPEN_STATUS_MID      = 8'h66;
    localparam logic [IDX_W-1:0] IDX_OPEN_STATUS_TOP      = 8'h67;
    localparam logic [IDX_W-1:0] IDX_SHORT_STATUS_LOW     = 8'h86;
    localparam logic [IDX_W-1:0] IDX_SHORT_STATUS_MID     = 8'h87;
    localparam logic [IDX_W-1:0] IDX_SHORT_STATUS_TOP     = 8'h88;
    localparam logic [IDX_W-1:0] IDX_OPEN_FLAG_CLEAR      = 8'hA7;
    localparam logic [IDX_W-1:0] IDX_SHORT_FLAG_CLEAR     = 8'hA8;

    // -----------------------------------------------------------------
    // fields and reset values
    // -----------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_CHANNEL_ENABLE_MID = 8'hFF;
    localparam logic [1:0]       RST_CHANNEL_ENABLE_TOP = 2'h3;
    localparam int unsigned      POS_GLOBAL_OPEN        = 1;
    localparam int unsigned      POS_GLOBAL_SHORT       = 0;
    localparam logic [3:0]       FLAG_CLEAR_KEY         = 4'hF;
    localparam logic [31:0]      READ_ZERO              = 32'h0000_0000;

endpackage

// *** rtl/ldef_regs.sv ***
// Behaviour
// - enable bits 2..7 of mid register switch channels 10..15 on when one.
// - bit 1 of mid register drives channel 9, bit 0 channel 8.
// - mid enable register at 0x44 resets to all ones.
// - top register 0x45 holds channels 17,16 in bits 1,0; rest read zero.
// - global fault bit 1 reads one if any channel has an open fault.
// - global fault bit 0 reads one on any short; bits 7..2 read zero.
// - open status 0x65 shows channels 0..7, channel n at bit n.
// - open status 0x66 shows channels 8..15, channel 8+n at bit n.
// - open status 0x67 is decoded for the remaining channels.
// - short status registers at 0x86, 0x87, 0x88 are decoded.
// - open status top bit 1 is channel 17, bit 0 channel 16.
// - short bit reads one when shorted; channels map low, mid, top.
// - writing 0xF to 0xA7 clears all open flags, channel and global.
// - writing 0xF to 0xA8 clears all short flags, channel and global.
//
// Purpose: led channel enable and fault status register bank on apb
// Assumes: open and short detect pulses come synchronous to mclk
// Notes:   zero wait states; register index is byte address divided by four
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
module ldef_regs
    import ldef_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    reset,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [NUM_CHANNELS-1:0] open_detect,
    input  wire logic [NUM_CHANNELS-1:0] short_detect,
    output logic      [NUM_CHANNELS-1:8] channel_enable
);

    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    logic                    wr_en;
    logic [IDX_W-1:0]        idx;
    logic [REG_W-1:0]        channel_enable_mid_r;
    logic [1:0]              channel_enable_top_r;
    logic [NUM_CHANNELS-1:0] open_flags;
    logic [NUM_CHANNELS-1:0] short_flags;
    logic                    open_any;
    logic                    short_any;
    logic                    open_clear;
    logic                    short_clear;
    logic [REG_W-1:0]        rd_nxt;
    logic                    hit;

    // -----------------------------------------------------------------
    // register map, byte address is index times four, data in bits 7..0
    // -----------------------------------------------------------------
    // 0x110  channel_enable_mid    rw  ch15..ch10 in 7..2, ch9 in 1, ch8 in 0
    // 0x114  channel_enable_top    rw  ch17 in 1, ch16 in 0, 7..2 read zero
    // 0x190  global_fault_summary  ro  open summary in 1, short summary in 0
    // 0x194  open_status_low       ro  ch7..ch0
    // 0x198  open_status_mid       ro  ch15..ch8
    // 0x19C  open_status_top       ro  ch17 in 1, ch16 in 0
    // 0x218  short_status_low      ro  ch7..ch0
    // 0x21C  short_status_mid      ro  ch15..ch8
    // 0x220  short_status_top      ro  ch17 in 1, ch16 in 0
    // 0x29C  open flag clear       wo  acts only on key 0xF in 3..0
    // 0x2A0  short flag clear      wo  acts only on key 0xF in 3..0
    // any other word address answers with pslverr, reads zero and ignores writes; address bits 1..0 are ignored
    // a detect in the cycle of its clear keeps the flag set, so no fault is lost

    // -----------------------------------------------------------------
    // bus front end
    // -----------------------------------------------------------------
    ldef_apb_if u_apb (
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .wr_en   (wr_en),
        .rd_en   (),
        .idx     (idx)
    );

    // bulk clear strobes, only the key value acts
    assign open_clear  = wr_en && idx == IDX_OPEN_FLAG_CLEAR
                         && pwdata[3:0] == FLAG_CLEAR_KEY;
    assign short_clear = wr_en && idx == IDX_SHORT_FLAG_CLEAR
                         && pwdata[3:0] == FLAG_CLEAR_KEY;

    // -----------------------------------------------------------------
    // fault flag banks
    // -----------------------------------------------------------------
    ldef_flag_bank #(.N(NUM_CHANNELS)) u_open (
        .mclk    (mclk),
        .reset   (reset),
        .detect  (open_detect),
        .clear   (open_clear),
        .flags_r (open_flags),
        .any_r   (open_any)
    );

    ldef_flag_bank #(.N(NUM_CHANNELS)) u_short (
        .mclk    (mclk),
        .reset   (reset),
        .detect  (short_detect),
        .clear   (short_clear),
        .flags_r (short_flags),
        .any_r   (short_any)
    );

    // -----------------------------------------------------------------
    // enable registers
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            channel_enable_mid_r <= RST_CHANNEL_ENABLE_MID;
        end else if (wr_en && idx == IDX_CHANNEL_ENABLE_MID) begin
            channel_enable_mid_r <= pwdata[REG_W-1:0];
        end
    end

    // top enables, reserved bits not stored
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            channel_enable_top_r <= RST_CHANNEL_ENABLE_TOP;
        end else if (wr_en && idx == IDX_CHANNEL_ENABLE_TOP) begin
            channel_enable_top_r <= pwdata[1:0];
        end
    end

    // enables to the current sinks, registered
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            channel_enable <= {RST_CHANNEL_ENABLE_TOP, RST_CHANNEL_ENABLE_MID};
        end else begin
            channel_enable <= {channel_enable_top_r, channel_enable_mid_r};
        end
    end

    // -----------------------------------------------------------------
    // read decode; status registers have no write path
    // -----------------------------------------------------------------
    always_comb begin
        rd_nxt = '0;
        hit    = 1'b1;
        if (|paddr[ADDR_W-1:IDX_W+2]) begin
            hit = 1'b0;
        end else if (idx == IDX_CHANNEL_ENABLE_MID) begin
            rd_nxt = channel_enable_mid_r;
        end else if (idx == IDX_CHANNEL_ENABLE_TOP) begin
            rd_nxt = {6'h00, channel_enable_top_r};
        end else if (idx == IDX_GLOBAL_FAULT_SUMMARY) begin
            rd_nxt[POS_GLOBAL_OPEN]  = open_any;
            rd_nxt[POS_GLOBAL_SHORT] = short_any;
        end else if (idx == IDX_OPEN_STATUS_LOW) begin
            rd_nxt = open_flags[7:0];
        end else if (idx == IDX_OPEN_STATUS_MID) begin
            rd_nxt = open_flags[15:8];
        end else if (idx == IDX_OPEN_STATUS_TOP) begin
            rd_nxt = {6'h00, open_flags[17:16]};
        end else if (idx == IDX_SHORT_STATUS_LOW) begin
            rd_nxt = short_flags[7:0];
        end else if (idx == IDX_SHORT_STATUS_MID) begin
            rd_nxt = short_flags[15:8];
        end else if (idx == IDX_SHORT_STATUS_TOP) begin
            rd_nxt = {6'h00, short_flags[17:16]};
        end else if (idx == IDX_OPEN_FLAG_CLEAR || idx == IDX_SHORT_FLAG_CLEAR) begin
            rd_nxt = '0;                                        // write only
        end else begin
            hit = 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // apb answer: registered, ready in the access cycle
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;                          // high in the access cycle
        end
    end

    // read data and error, launched with pready
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prdata  <= READ_ZERO;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            prdata  <= pwrite ? READ_ZERO : {24'h00_0000, rd_nxt};
            pslverr <= ~hit;
        end else begin
            prdata  <= READ_ZERO;
            pslverr <= 1'b0;
        end
    end

endmodule // ldef_regs

// *** test/ldef_regs_chk.sv ***
// Purpose: port-level checks of the enable and fault register bank
// Assumes: no wait state per apb access, byte address is index times four
// Notes:   channel_enable lags its register by one cycle
`timescale 1ns/10ps
module ldef_regs_chk
    import ldef_pkg::*;
(
    input wire logic                    mclk,
    input wire logic                    reset,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [ADDR_W-1:0]       paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic [NUM_CHANNELS-1:0] open_detect,
    input wire logic [NUM_CHANNELS-1:0] short_detect,
    input wire logic [NUM_CHANNELS-1:8] channel_enable
);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    wire wr_ok = psel && penable && pwrite && pready;
    wire rd_ok = pready && !pwrite;
    property p_ready_setup; psel && !penable |=> pready; endproperty
    property p_ready_single; pready |=> !pready; endproperty
    property p_en_mid;
        wr_ok && paddr == 12'h110 |-> ##2 channel_enable[15:8] == $past(pwdata[7:0], 2);
    endproperty
    property p_en_top;
        wr_ok && paddr == 12'h114 |-> ##2 channel_enable[17:16] == $past(pwdata[1:0], 2);
    endproperty
    property p_fault_resv; rd_ok && paddr == 12'h190 |-> prdata[7:2] == 6'h0; endproperty
    property p_top_resv;
        rd_ok && paddr inside {12'h114, 12'h19C, 12'h220} |-> prdata[7:2] == 6'h0;
    endproperty
    property p_mapped;
        pready && paddr inside {12'h110, 12'h114, 12'h190, 12'h194, 12'h198, 12'h19C,
            12'h218, 12'h21C, 12'h220} |-> !pslverr;
    endproperty
    property p_upper_zero; pready |-> prdata[31:8] == 24'h00_0000; endproperty
    property p_unmapped;
        pready && paddr == 12'h000 |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_ready_setup: assert property (p_ready_setup) else $error("no ready after setup");
    a_ready_single: assert property (p_ready_single) else $error("ready held too long");
    a_en_mid: assert property (p_en_mid) else $error("mid enable mismatch");
    a_en_top: assert property (p_en_top) else $error("top enable mismatch");
    a_fault_resv: assert property (p_fault_resv) else $error("fault upper bits");
    a_top_resv: assert property (p_top_resv) else $error("top upper bits");
    a_mapped: assert property (p_mapped) else $error("mapped reg refused");
    a_upper_zero: assert property (p_upper_zero) else $error("high bits set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    c_wr_mid: cover property (wr_ok && paddr == 12'h110);
    c_rd_fault: cover property (rd_ok && paddr == 12'h190);
    c_unmapped: cover property (pready && pslverr);
endmodule // ldef_regs_chk

bind ldef_regs ldef_regs_chk i_chk (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .open_detect(open_detect),
    .short_detect(short_detect), .channel_enable(channel_enable));

// *** test/ldef_regs_tb_top.sv ***
// Purpose: directed bench of the enable and fault register bank
// Assumes: apb master waits for pready under a bounded count
// Notes:   detects are one-cycle pulses
`timescale 1ns/10ps
module ldef_regs_tb_top;
    import ldef_pkg::*;
    logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic        pready, pslverr;
    logic [17:0] open_detect = 0, short_detect = 0;
    logic [17:8] channel_enable;
    int          n_mismatch = 0, n_compared = 0;
    // ---------------------------------------------------------------
    // clock, dut and tasks
    // ---------------------------------------------------------------
    initial forever #20 mclk = ~mclk;
    ldef_regs i_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .open_detect(open_detect), .short_detect(short_detect),
        .channel_enable(channel_enable));
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        @(posedge mclk);
        for (k = 0; pready !== 1'b1 && k < 20; k++) @(posedge mclk);
        if (k == 20) begin
            n_mismatch++;
            conclude();
        end
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 32'h0000_0000);
        chk(r, x);
    endtask
    task automatic pulse(input bit s, input logic [17:0] v);
        @(posedge mclk);
        if (s) short_detect <= v;
        else open_detect <= v;
        @(posedge mclk);
        open_detect <= 0; short_detect <= 0;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        logic [11:0] st [7] = '{12'h190, 12'h194, 12'h198, 12'h19C, 12'h218, 12'h21C, 12'h220};
        rd(12'h110, 32'h0000_00FF);
        rd(12'h114, 32'h0000_0003);
        chk({22'h0, channel_enable}, 32'h0000_03FF);
        foreach (st[i]) rd(st[i], 32'h0000_0000);
    endtask
    task automatic t_enable();
        apb(1, 12'h110, 32'h0000_01A5);
        rd(12'h110, 32'h0000_00A5);
        chk({24'h0, channel_enable[15:8]}, 32'h0000_00A5);
        apb(1, 12'h114, 32'h0000_00FE);
        rd(12'h114, 32'h0000_0002);
        chk({30'h0, channel_enable[17:16]}, 32'h0000_0002);
    endtask
    // faults on channels 0, 9 and 17, then ignored writes and the keyed clear
    task automatic t_fault(input bit s);
        logic [11:0] b, c;
        logic [31:0] g;
        b = s ? 12'h218 : 12'h194;
        c = s ? 12'h2A0 : 12'h29C;
        g = s ? 32'h0000_0001 : 32'h0000_0002;
        pulse(s, 18'h2_0201);
        rd(b, 32'h0000_0001);
        rd(b + 12'h004, 32'h0000_0002);
        rd(b + 12'h008, 32'h0000_0002);
        rd(12'h190, g);
        apb(1, b, 32'h0000_0000);
        apb(1, 12'h190, 32'h0000_0000);
        rd(b, 32'h0000_0001);
        apb(1, c, 32'h0000_0005);
        rd(12'h190, g);
        apb(1, c, 32'h0000_000F);
        rd(b, 32'h0000_0000);
        rd(b + 12'h004, 32'h0000_0000);
        rd(b + 12'h008, 32'h0000_0000);
        rd(12'h190, 32'h0000_0000);
    endtask
    // detect at the access edge of the keyed clear: the detect wins
    task automatic t_collide();
        fork
            apb(1, 12'h29C, 32'h0000_000F);
            begin
                repeat (2) @(posedge mclk);
                open_detect <= 18'h0_0010;
                @(posedge mclk);
                open_detect <= 18'h0_0000;
            end
        join
        rd(12'h194, 32'h0000_0010);
        rd(12'h190, 32'h0000_0002);
        apb(1, 12'h29C, 32'h0000_000F);
        rd(12'h194, 32'h0000_0000);
    endtask
    task automatic t_unmapped();
        rd(12'h000, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        rd(12'h510, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        apb(1, 12'h510, 32'h0000_0000);
        rd(12'h110, 32'h0000_00A5);
        apb(1, 12'h004, 32'h0000_00FF);
        rd(12'h004, 32'h0000_0000);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        reset <= 0;
        t_reset();
        t_enable();
        t_fault(0);
        t_fault(1);
        t_collide();
        t_unmapped();
        conclude();
    end
endmodule // ldef_regs_tb_top
